// ### irq_arbiter.sv
// three_level_vectored_irq_arbiter: latches source flags, picks one vector
// assumes the core acks a shown grant with ack_in and signals handler
// return with reti_in; flags are cleared by software through flag_clr_in
`timescale 1ns/1ps
`default_nettype none
module three_level_vectored_irq_arbiter (
  input  wire logic                            core_clk_in,
  input  wire logic                            rstn_in,
  input  wire irq_arb_pkg::src_req_t           src_req_in,
  input  wire logic [irq_arb_pkg::NUM_SRC-1:0] src_en_in,
  input  wire logic [irq_arb_pkg::NUM_VEC-1:0] vec_upper_sel_in,
  input  wire logic [irq_arb_pkg::NUM_SRC-1:0] flag_clr_in,
  input  wire logic                            ack_in,
  input  wire logic                            reti_in,
  output logic                                 irq_req_out,
  output irq_arb_pkg::grant_t                  grant_out,
  output logic [irq_arb_pkg::NUM_SRC-1:0]      flag_out,
  output irq_arb_pkg::level_t                  svc_lvl_out
);
  import irq_arb_pkg::*;

  arb_state_t         state_q;
  arb_state_t         state_d;
  logic [NUM_SRC-1:0] src_vec;
  level_t             vec_lvl [NUM_VEC];
  level_t             best_lvl;
  logic [VEC_W-1:0]   best_idx;
  level_t             cur_lvl_q;
  level_t             cur_lvl_d;

  // the two pulse channels share one flag so nineteen flags remain
  assign src_vec = {src_req_in.port0_irq,
                    src_req_in.pulse_chan_a_irq | src_req_in.pulse_chan_b_irq,
                    src_req_in.timer_d_irq,
                    src_req_in.timer_c_irq,
                    src_req_in.adc_irq,
                    src_req_in.async_tx_irq,
                    src_req_in.sync_serial_b_irq,
                    src_req_in.async_rx_irq,
                    src_req_in.sync_serial_a_irq,
                    src_req_in.timer_b_high_irq,
                    src_req_in.timer_b_low_irq,
                    src_req_in.timer_a_high_irq,
                    src_req_in.base_timer_irq,
                    src_req_in.ext_pin_irq_d,
                    src_req_in.ext_pin_irq_e,
                    src_req_in.timer_a_low_irq,
                    src_req_in.ext_pin_irq_c,
                    src_req_in.ext_pin_irq_b,
                    src_req_in.ext_pin_irq_a};

  // vector levels are formed from the registered flags of this cycle
  for (genvar v = 0; v < NUM_VEC; v++) begin : g_slot
    irq_vector_slot #(
      .SRC_MASK (VEC_SRC_MASK[v]),
      .TOP_OK   (v < NUM_TOP)
    ) u_slot (
      .pend_in      (state_q.pend),
      .en_in        (src_en_in),
      .upper_sel_in (vec_upper_sel_in[v]),
      .lvl_out      (vec_lvl[v])
    );
  end

  function automatic level_t top_level(input logic [2:0] svc);
    if (svc[2]) begin
      return LVL_HIGHEST;
    end else if (svc[1]) begin
      return LVL_HIGH;
    end else if (svc[0]) begin
      return LVL_LOW;
    end
    return LVL_NONE;
  endfunction

  assign cur_lvl_q = top_level(state_q.in_svc);

  // walk down so the last hit at the top level is the smallest vector
  always_comb begin
    best_lvl = LVL_NONE;
    best_idx = '0;
    for (int v = NUM_VEC - 1; v >= 0; v--) begin
      if (vec_lvl[v] != LVL_NONE && vec_lvl[v] >= best_lvl) begin
        best_lvl = vec_lvl[v];
        best_idx = VEC_W'(v);
      end
    end
  end

  always_comb begin
    state_d = state_q;
    // a source pulse in the clear cycle still leaves its flag set
    state_d.pend = (state_q.pend & ~flag_clr_in) | src_vec;
    // return drops only the innermost level, uncovering the one beneath
    if (reti_in) begin
      if (state_q.in_svc[2]) begin
        state_d.in_svc[2] = 1'b0;
      end else if (state_q.in_svc[1]) begin
        state_d.in_svc[1] = 1'b0;
      end else begin
        state_d.in_svc[0] = 1'b0;
      end
    end
    if (ack_in && state_q.gnt.req && state_q.gnt.lvl != LVL_NONE) begin
      state_d.in_svc[state_q.gnt.lvl - 2'b01] = 1'b1;
    end
    cur_lvl_d = top_level(state_d.in_svc);
    // a grant is withdrawn at once when an ack raises the service level
    state_d.gnt.req  = (best_lvl > cur_lvl_d);
    state_d.gnt.idx  = best_idx;
    state_d.gnt.lvl  = best_lvl;
    state_d.gnt.addr = VEC_BASE + ADDR_W'(best_idx) * VEC_STEP;
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign irq_req_out = state_q.gnt.req;
  assign grant_out   = state_q.gnt;
  assign flag_out    = state_q.pend;
  assign svc_lvl_out = cur_lvl_q;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  a_refuse_not_above: assert property (
    irq_req_out |-> grant_out.lvl > cur_lvl_q
  ) else $error("grant not above in-service level");

  a_top_pins_only: assert property (
    irq_req_out && grant_out.lvl == LVL_HIGHEST |-> grant_out.idx < 4'h2
  ) else $error("highest level on a non-pin vector");

  a_high_no_pins: assert property (
    irq_req_out && grant_out.lvl == LVL_HIGH |-> grant_out.idx >= 4'h2
  ) else $error("high level on a pin vector");

  a_addr_in_map: assert property (
    irq_req_out |-> grant_out.addr <= 17'h0004B && grant_out.addr[2:0] == 3'h3
  ) else $error("vector address outside map");

  a_best_level_wins: assert property (
    best_lvl > cur_lvl_q && !ack_in && !reti_in |=> irq_req_out
      && grant_out.lvl == $past(best_lvl)
  ) else $error("highest pending level not granted");

  a_tie_smallest_vec: assert property (
    vec_lvl[0] == LVL_LOW && vec_lvl[9] == LVL_LOW && best_lvl == LVL_LOW
      |-> best_idx == 4'h0
  ) else $error("tie not broken by smallest vector");

  a_set_beats_clear: assert property (
    src_vec != '0 |=> (flag_out & $past(src_vec)) == $past(src_vec)
  ) else $error("source pulse lost");

  a_ack_nests: assert property (
    ack_in && irq_req_out && !reti_in |=> svc_lvl_out == $past(grant_out.lvl)
      ##1 !irq_req_out || grant_out.lvl > svc_lvl_out
  ) else $error("ack did not raise service level");

  a_disabled_silent: assert property (
    src_en_in == '0 [*2] |-> !irq_req_out
  ) else $error("grant with all sources disabled");

  a_reti_drops_level: assert property (
    reti_in && !ack_in && svc_lvl_out != LVL_NONE
      |=> svc_lvl_out < $past(svc_lvl_out)
  ) else $error("return did not lower service level");

  a_flag_stands: assert property (
    flag_clr_in == '0 |=> (flag_out & $past(flag_out)) == $past(flag_out)
  ) else $error("pending flag lost without a clear");

  a_clear_drops_flag: assert property (
    flag_clr_in != '0 && src_vec == '0
      |=> (flag_out & $past(flag_clr_in)) == '0
  ) else $error("cleared flag still pending");

  a_top_blocks_all: assert property (
    svc_lvl_out == LVL_HIGHEST |-> !irq_req_out
  ) else $error("grant while highest level in service");

  // a smaller vector at the chosen level would break the tie order
  logic tie_smaller;

  always_comb begin
    tie_smaller = 1'b0;
    for (int v = 0; v < NUM_VEC; v++) begin
      if (VEC_W'(v) < best_idx && vec_lvl[v] == best_lvl) begin
        tie_smaller = 1'b1;
      end
    end
  end

  a_tie_any_vec: assert property (
    best_lvl != LVL_NONE |-> !tie_smaller
  ) else $error("smaller vector at same level passed over");

  c_plain_grant: cover property (
    !irq_req_out ##1 irq_req_out ##1 ack_in);
  c_nested_grant: cover property (
    svc_lvl_out == LVL_LOW && irq_req_out && grant_out.lvl == LVL_HIGH);
  c_top_grant: cover property (
    irq_req_out && grant_out.lvl == LVL_HIGHEST);
  c_return: cover property (reti_in && svc_lvl_out != LVL_NONE);
  c_set_with_clear: cover property (
    src_vec != '0 && flag_clr_in != '0);

endmodule // three_level_vectored_irq_arbiter
`default_nettype wire

// ### irq_arb_pkg.sv
// irq_arb_pkg: constants and types shared by the vectored interrupt arbiter
// assumes one synchronous system clock domain for all users
package irq_arb_pkg;

  localparam int unsigned NUM_SRC  = 19;
  localparam int unsigned NUM_VEC  = 10;
  localparam int unsigned VEC_W    = 4;
  localparam int unsigned ADDR_W   = 17;
  localparam int unsigned NUM_TOP  = 2;

  // first vector address and spacing between vectors
  localparam logic [ADDR_W-1:0] VEC_BASE = 17'h00003;
  localparam logic [ADDR_W-1:0] VEC_STEP = 17'h00008;

  // which flags share each vector, indexed by vector number
  localparam logic [NUM_SRC-1:0] VEC_SRC_MASK [NUM_VEC] = '{
    19'h00001, 19'h00002, 19'h0001C, 19'h00060, 19'h00080,
    19'h00300, 19'h00C00, 19'h03000, 19'h3C000, 19'h40000
  };

  typedef enum logic [1:0] {
    LVL_NONE    = 2'b00,
    LVL_LOW     = 2'b01,
    LVL_HIGH    = 2'b10,
    LVL_HIGHEST = 2'b11
  } level_t;

  // one-cycle request pulses from pins and peripherals
  typedef struct packed {
    logic ext_pin_irq_a;
    logic ext_pin_irq_b;
    logic ext_pin_irq_c;
    logic timer_a_low_irq;
    logic ext_pin_irq_e;
    logic ext_pin_irq_d;
    logic base_timer_irq;
    logic timer_a_high_irq;
    logic timer_b_low_irq;
    logic timer_b_high_irq;
    logic sync_serial_a_irq;
    logic async_rx_irq;
    logic sync_serial_b_irq;
    logic async_tx_irq;
    logic adc_irq;
    logic timer_c_irq;
    logic timer_d_irq;
    logic pulse_chan_a_irq;
    logic pulse_chan_b_irq;
    logic port0_irq;
  } src_req_t;

  // grant presented to the processor core
  typedef struct packed {
    logic              req;
    logic [VEC_W-1:0]  idx;
    level_t            lvl;
    logic [ADDR_W-1:0] addr;
  } grant_t;

  typedef struct packed {
    logic [NUM_SRC-1:0] pend;
    logic [2:0]         in_svc;
    grant_t             gnt;
  } arb_state_t;

endpackage

// ### irq_vector_slot.sv
// irq_vector_slot: request and level of one vector from its shared flags
// assumes flags arrive registered from the arbiter; enables come straight from its src_en_in input
`timescale 1ns/1ps
`default_nettype none
module irq_vector_slot #(
  parameter logic [irq_arb_pkg::NUM_SRC-1:0] SRC_MASK = '0,
  parameter bit                              TOP_OK   = 1'b0
) (
  input  wire logic [irq_arb_pkg::NUM_SRC-1:0] pend_in,
  input  wire logic [irq_arb_pkg::NUM_SRC-1:0] en_in,
  input  wire logic                            upper_sel_in,
  output irq_arb_pkg::level_t                  lvl_out
);
  import irq_arb_pkg::*;

  always_comb begin
    if (|(pend_in & en_in & SRC_MASK)) begin
      if (!upper_sel_in) begin
        lvl_out = LVL_LOW;
      end else if (TOP_OK) begin
        lvl_out = LVL_HIGHEST;
      end else begin
        lvl_out = LVL_HIGH;
      end
    end else begin
      lvl_out = LVL_NONE;
    end
  end

endmodule // irq_vector_slot
`default_nettype wire

// ### core_model.sv
// core_model: stand-in for the processor core that takes grants
// assumes the arbiter's grant is registered and stands until taken
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic                              core_clk_in,
  input  wire logic                              rstn_in,
  input  wire logic                              irq_req_in,
  input  wire irq_arb_pkg::grant_t               grant_in,
  input  wire logic                              take_in,
  input  wire logic                              ret_in,
  output logic                                   ack_out,
  output logic                                   reti_out,
  output logic [irq_arb_pkg::ADDR_W-1:0]         vec_addr_out
);
  import irq_arb_pkg::*;
  // one ack per grant, so a shown grant is never taken twice
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_out      <= 1'b0;
      reti_out     <= 1'b0;
      vec_addr_out <= '0;
    end else begin
      ack_out  <= take_in && irq_req_in && !ack_out;
      reti_out <= ret_in;
      if (ack_out && irq_req_in) begin
        vec_addr_out <= grant_in.addr;
      end
    end
  end
endmodule // core_model
`default_nettype wire

// ### three_level_vectored_irq_arbiter_test.sv
// three_level_vectored_irq_arbiter_test: directed bench for the arbiter
// assumes core_model stands in for the core on the grant side
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_fail++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module three_level_vectored_irq_arbiter_test;
  import irq_arb_pkg::*;
  logic        core_clk_in = 1'b0;
  logic        rstn_in     = 1'b0;
  src_req_t    src_req     = '0;
  logic [18:0] en          = 19'h7FFFE;
  logic [18:0] clr         = '0;
  logic [18:0] flag;
  logic [9:0]  sel         = '0;
  logic        ack, reti, req;
  logic        take        = 1'b0;
  logic        ret         = 1'b0;
  grant_t      gnt;
  level_t      svc;
  logic [16:0] vaddr;
  int          n_fail      = 0;
  int          checks_done = 0;
  always #5 core_clk_in = ~core_clk_in;
  three_level_vectored_irq_arbiter three_level_vectored_irq_arbiter_inst (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .src_req_in(src_req),
    .src_en_in(en), .vec_upper_sel_in(sel), .flag_clr_in(clr),
    .ack_in(ack), .reti_in(reti), .irq_req_out(req), .grant_out(gnt),
    .flag_out(flag), .svc_lvl_out(svc));
  core_model core_model_inst (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .irq_req_in(req),
    .grant_in(gnt), .take_in(take), .ret_in(ret), .ack_out(ack),
    .reti_out(reti), .vec_addr_out(vaddr));
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // flag numbers map onto the request struct, MSB first
  task automatic pulse(input logic [18:0] f);
    logic [19:0] v;
    v = '0;
    for (int n = 0; n < 17; n++) v[19-n] = f[n];
    v[2] = f[17];
    v[0] = f[18];
    @(posedge core_clk_in) src_req <= src_req_t'(v);
    @(posedge core_clk_in) src_req <= '0;
  endtask
  task automatic wait_on(input bit by_svc, input level_t l);
    int i;
    for (i = 0; i < 20; i++) begin
      @(negedge core_clk_in);
      if (by_svc ? svc === l : req === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      $display("[FAIL] wait exp %0h got %0h", l, svc);
      final_report();
    end
  endtask
  task automatic chk_gnt(input logic [3:0] i, input level_t l,
                         input logic [16:0] a);
    wait_on(1'b0, LVL_NONE);
    `CHK("idx", i, gnt.idx)
    `CHK("lvl", l, gnt.lvl)
    `CHK("addr", a, gnt.addr)
  endtask
  task automatic clear_all();
    @(posedge core_clk_in) clr <= '1;
    @(posedge core_clk_in) clr <= '0;
    repeat (3) @(negedge core_clk_in);
    `CHK("req", 1'b0, req)
  endtask
  task automatic take_it(input level_t l);
    @(posedge core_clk_in) take <= 1'b1;
    wait_on(1'b1, l);
    @(posedge core_clk_in) take <= 1'b0;
    @(negedge core_clk_in);
    `CHK("svc", l, svc)
  endtask
  task automatic ret_to(input level_t l);
    @(posedge core_clk_in) ret <= 1'b1;
    @(posedge core_clk_in) ret <= 1'b0;
    wait_on(1'b1, l);
    `CHK("svc", l, svc)
  endtask
  // disabled vector 0 must lose to the enabled low vectors
  task automatic t_tie();
    pulse(19'h00105);
    @(negedge core_clk_in);
    `CHK("flag", 19'h00105, flag)
    chk_gnt(4'h2, LVL_LOW, 17'h00013);
    clear_all();
    $display("t_tie done");
  endtask
  task automatic t_nest();
    @(posedge core_clk_in) sel <= 10'h200;
    pulse(19'h40002);
    chk_gnt(4'h9, LVL_HIGH, 17'h0004B);
    take_it(LVL_HIGH);
    `CHK("fetch", 17'h0004B, vaddr)
    @(posedge core_clk_in) sel <= 10'h210;
    pulse(19'h00080);
    repeat (3) @(negedge core_clk_in);
    `CHK("req", 1'b0, req)
    @(posedge core_clk_in) sel <= 10'h212;
    chk_gnt(4'h1, LVL_HIGHEST, 17'h0000B);
    take_it(LVL_HIGHEST);
    clear_all();
    ret_to(LVL_HIGH);
    ret_to(LVL_NONE);
    $display("t_nest done");
  endtask
  // all enables off keeps a pending tie silent; then vector 0 beats 9
  task automatic t_mask();
    @(posedge core_clk_in) en <= '0;
    sel <= '0;
    pulse(19'h40001);
    repeat (3) @(negedge core_clk_in);
    `CHK("flag", 19'h40001, flag)
    `CHK("req", 1'b0, req)
    @(posedge core_clk_in) en <= '1;
    chk_gnt(4'h0, LVL_LOW, 17'h00003);
    take_it(LVL_LOW);
    `CHK("fetch", 17'h00003, vaddr)
    @(posedge core_clk_in) rstn_in <= 1'b0;
    @(posedge core_clk_in) rstn_in <= 1'b1;
    @(negedge core_clk_in);
    `CHK("svc", LVL_NONE, svc)
    `CHK("flag", 19'h00000, flag)
    `CHK("req", 1'b0, req)
    $display("t_mask done");
  endtask
  // a source pulse in the cycle of a clear keeps its flag
  task automatic t_set_clear();
    pulse(19'h00004);
    @(posedge core_clk_in) src_req <= src_req_t'(20'h00001);
    clr <= '1;
    @(posedge core_clk_in) src_req <= '0;
    clr <= '0;
    @(negedge core_clk_in);
    `CHK("flag", 19'h40000, flag)
    chk_gnt(4'h9, LVL_LOW, 17'h0004B);
    clear_all();
    $display("t_set_clear done");
  endtask
  initial begin
    repeat (3) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    @(negedge core_clk_in);
    `CHK("req", 1'b0, req)
    `CHK("svc", LVL_NONE, svc)
    `CHK("flag", 19'h00000, flag)
    $display("t_reset done");
    t_tie();
    t_nest();
    t_mask();
    t_set_clear();
    final_report();
  end
endmodule // three_level_vectored_irq_arbiter_test
`default_nettype wire
